// ### hw/snvm_regs.vh
// constants for the serial nonvolatile memory slave
`ifndef SNVM_REGS_VH
`define SNVM_REGS_VH
`define SNVM_MEM_DEPTH      2048
`define SNVM_ADDR_W         11
`define SNVM_ROW_W          8
`define SNVM_SEG_W          3
`define SNVM_BYTE_BITS      4'h8
`define SNVM_TYPE_MSB       7
`define SNVM_TYPE_LSB       4
`define SNVM_SEG_MSB        3
`define SNVM_SEG_LSB        1
`define SNVM_RW_BIT         0
// device-type code; value arbitrary
`define SNVM_DEV_TYPE       4'h5
`define SNVM_ADDR_RST       11'h000
`define SNVM_ADDR_LAST      11'h7FF
`define SNVM_BUF_DEPTH      2
`define SNVM_CLK_HZ         20000000
`define SNVM_SCL_MAX_HZ     1000000
`define SNVM_SCL_MIN_CYC    (`SNVM_CLK_HZ / (2 * `SNVM_SCL_MAX_HZ))
`endif

// ### hw/snvm_slave.v
// two-wire serial slave front end of a 2048 x 8 nonvolatile memory
// Function
// - sample data on clock rise, change output data on clock fall
// - data line only pulled low or released, never driven high
// - each byte is eight bits shifted serially, one per clock
// - write-protect high blocks writes to the whole array
// - write-protect low allows writes everywhere
// - write-protect held low internally when left unconnected
// - array of 2048 byte-wide locations
// - 8-bit row field selects one of 256 rows
// - 3-bit segment joins row to form 11-bit address
// - write byte committed right after its eighth bit
// - write finished before any following transaction shifts in
// - works with bus clock up to 1 MHz, also 100 and 400 kHz
// - power-on reset puts the interface idle
// - first byte: type in 7..4, segment in 3..1, direction bit 0
// - address increments after each data byte, wraps to zero
// - reads continue while master acknowledges, end on no-acknowledge
// - protected writes get no acknowledge and no address increment
`timescale 1ns/1ps
`include "snvm_regs.vh"
module snvm_slave (
   input  wire       clk_i,
   input  wire       srst_i,
   input  wire       scl_i,
   input  wire       sda_i,
   input  wire       wp_i,
   output reg        sda_o,
   output reg        sda_oe_n_o,
   output reg        busy_o
);
   localparam ST_IDLE = 3'h0;
   localparam ST_DEV  = 3'h1;
   localparam ST_WADR = 3'h2;
   localparam ST_WDAT = 3'h3;
   localparam ST_RDAT = 3'h4;
   localparam ST_RACK = 3'h5;
   // ignore state keeps the line released until the next start
   localparam ST_IGN  = 3'h6;

   // two-stage synchronisers; pins are foreign to clk_i
   reg  [1:0]  scl_sync_reg;
   reg  [1:0]  sda_sync_reg;
   reg  [1:0]  wp_sync_reg;
   reg         scl_d_reg;
   reg         sda_d_reg;
   wire        scl_s;
   wire        sda_s;
   wire        wp_s;
   wire        scl_rise;
   wire        scl_fall;
   wire        start_c;
   wire        stop_c;

   reg  [7:0]  mem [0:`SNVM_MEM_DEPTH-1];
   reg  [2:0]  state_reg;
   reg  [3:0]  bit_cnt_reg;
   reg  [7:0]  shift_reg;
   reg  [10:0] addr_reg;
   reg         ack_phase_reg;
   reg         ack_drive_reg;
   reg         tx_bit_reg;
   reg         tx_en_reg;
   reg  [7:0]  rd_byte_reg;
   reg         wp_byte_reg;

   // two-entry buffer between byte receiver and array write port
   reg  [18:0] buf_mem [0:`SNVM_BUF_DEPTH-1];
   reg         buf_wp_reg;
   reg         buf_rp_reg;
   reg  [1:0]  buf_cnt_reg;
   wire        buf_in_ready;
   wire        buf_out_valid;
   wire        buf_out_ready;
   reg         buf_in_valid;
   reg  [18:0] buf_in_data;

   assign scl_s    = scl_sync_reg[1];
   assign sda_s    = sda_sync_reg[1];
   // write-protect pulled low: an unconnected (x/z) pin is treated as low
   // weak pull-down
   assign wp_s     = (wp_sync_reg[1] === 1'b1);
   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   // start and stop need scl high on both samples, so data moved at scl low never counts
   assign start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   assign buf_in_ready  = (buf_cnt_reg != 2'h2);
   assign buf_out_valid = (buf_cnt_reg != 2'h0);
   // array port always free, so the drain never stalls for long
   assign buf_out_ready = 1'b1;

   // sampling lag three clocks
   // the lag needs a bus half period of at least ten clocks, which 1 MHz gives
   always @(posedge clk_i) begin
      if (srst_i) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         wp_sync_reg  <= 2'h0;
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_i};
         sda_sync_reg <= {sda_sync_reg[0], sda_i};
         wp_sync_reg  <= {wp_sync_reg[0], wp_i};
         scl_d_reg    <= scl_s;
         sda_d_reg    <= sda_s;
      end
   end

   // storage array; commit drains the buffer at once
   always @(posedge clk_i) begin
      if (buf_out_valid && buf_out_ready)
         mem[buf_mem[buf_rp_reg][18:8]] <= buf_mem[buf_rp_reg][7:0];
   end

   always @(posedge clk_i) begin
      if (buf_in_valid && buf_in_ready)
         buf_mem[buf_wp_reg] <= buf_in_data;
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         buf_wp_reg  <= 1'b0;
         buf_rp_reg  <= 1'b0;
         buf_cnt_reg <= 2'h0;
      end else begin
         if (buf_in_valid && buf_in_ready)
            buf_wp_reg <= ~buf_wp_reg;
         if (buf_out_valid && buf_out_ready)
            buf_rp_reg <= ~buf_rp_reg;
         case ({buf_in_valid && buf_in_ready, buf_out_valid && buf_out_ready})
            2'b10:   buf_cnt_reg <= buf_cnt_reg + 2'h1;
            2'b01:   buf_cnt_reg <= buf_cnt_reg - 2'h1;
            default: buf_cnt_reg <= buf_cnt_reg;
         endcase
      end
   end

   // write request toward the buffer on the eighth rising edge of a data byte
   // protect blocks clear allows
   always @* begin
      buf_in_valid = (state_reg == ST_WDAT) && !ack_phase_reg && scl_rise &&
                     (bit_cnt_reg == 4'h7) && !wp_s;
      buf_in_data  = {addr_reg, shift_reg[6:0], sda_s};
   end

   // array read every clock; the next byte is ready long before its first bit
   always @(posedge clk_i) begin
      rd_byte_reg <= mem[addr_reg];
   end

   always @(posedge clk_i) begin
      // reset returns to idle with the line released
      if (srst_i) begin
         state_reg     <= ST_IDLE;
         bit_cnt_reg   <= 4'h0;
         shift_reg     <= 8'h00;
         addr_reg      <= `SNVM_ADDR_RST;
         ack_phase_reg <= 1'b0;
         ack_drive_reg <= 1'b0;
         tx_bit_reg    <= 1'b1;
         wp_byte_reg   <= 1'b0;
         tx_en_reg     <= 1'b0;
         busy_o        <= 1'b0;
      end else if (start_c) begin
         // start aborts anything in progress
         state_reg     <= ST_DEV;
         bit_cnt_reg   <= 4'h0;
         ack_phase_reg <= 1'b0;
         ack_drive_reg <= 1'b0;
         tx_en_reg     <= 1'b0;
         busy_o        <= 1'b1;
      end else if (stop_c) begin
         state_reg     <= ST_IDLE;
         ack_drive_reg <= 1'b0;
         tx_en_reg     <= 1'b0;
         busy_o        <= 1'b0;
      end else begin
         // busy drops one clock after the ignore state is entered
         busy_o <= (state_reg != ST_IDLE) && (state_reg != ST_IGN);
         case (state_reg)
            ST_IDLE, ST_IGN: begin
               ack_drive_reg <= 1'b0;
               tx_en_reg     <= 1'b0;
            end
            ST_DEV, ST_WADR, ST_WDAT: begin
               if (!ack_phase_reg && scl_rise) begin
                  shift_reg   <= {shift_reg[6:0], sda_s};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == 4'h7) begin
                     ack_phase_reg <= 1'b1;
                     // protect level frozen with the write request, so a pin
                     // change before the ack cannot split the write from its ack
                     wp_byte_reg   <= wp_s;
                  end
               end else if (ack_phase_reg && scl_fall && !ack_drive_reg &&
                            bit_cnt_reg == `SNVM_BYTE_BITS) begin
                  bit_cnt_reg <= 4'h0;
                  case (state_reg)
                     ST_DEV: begin
                        if (shift_reg[`SNVM_TYPE_MSB:`SNVM_TYPE_LSB] == `SNVM_DEV_TYPE) begin
                           addr_reg[10:8] <= shift_reg[`SNVM_SEG_MSB:`SNVM_SEG_LSB];
                           ack_drive_reg  <= 1'b1;
                        end else begin
                           state_reg     <= ST_IGN;
                           ack_phase_reg <= 1'b0;
                        end
                     end
                     ST_WADR: begin
                        addr_reg[7:0] <= shift_reg;
                        ack_drive_reg <= 1'b1;
                     end
                     default: begin
                        if (!wp_byte_reg) begin
                           addr_reg      <= addr_reg + 11'h001;
                           ack_drive_reg <= 1'b1;
                        end else begin
                           state_reg     <= ST_IGN;
                           ack_phase_reg <= 1'b0;
                        end
                     end
                  endcase
               end else if (ack_phase_reg && ack_drive_reg && scl_fall) begin
                  // ack clock done: release and move on
                  ack_drive_reg <= 1'b0;
                  ack_phase_reg <= 1'b0;
                  if (state_reg == ST_DEV) begin
                     if (shift_reg[`SNVM_RW_BIT]) begin
                        state_reg   <= ST_RDAT;
                        tx_en_reg   <= 1'b1;
                        tx_bit_reg  <= rd_byte_reg[7];
                        shift_reg   <= {rd_byte_reg[6:0], 1'b0};
                        bit_cnt_reg <= 4'h1;
                     end else begin
                        state_reg <= ST_WADR;
                     end
                  end else begin
                     state_reg <= ST_WDAT;
                  end
               end
            end
            ST_RDAT: begin
               // change out bits on falling edge
               if (scl_fall) begin
                  if (bit_cnt_reg == `SNVM_BYTE_BITS) begin
                     addr_reg    <= addr_reg + 11'h001;
                     tx_en_reg   <= 1'b0;
                     bit_cnt_reg <= 4'h0;
                     state_reg   <= ST_RACK;
                  end else begin
                     tx_bit_reg  <= shift_reg[7];
                     shift_reg   <= {shift_reg[6:0], 1'b0};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               // master answer bit: low asks for the next byte
               if (scl_rise) begin
                  if (sda_s)
                     state_reg <= ST_IGN;
                  else
                     bit_cnt_reg <= 4'hF;
               end else if (scl_fall && bit_cnt_reg == 4'hF) begin
                  state_reg   <= ST_RDAT;
                  tx_en_reg   <= 1'b1;
                  tx_bit_reg  <= rd_byte_reg[7];
                  shift_reg   <= {rd_byte_reg[6:0], 1'b0};
                  bit_cnt_reg <= 4'h1;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // open drain: low or released only
   // released outside ack and read data
   // sda_o stays zero; only the enable moves the wire
   always @(posedge clk_i) begin
      if (srst_i) begin
         sda_o      <= 1'b0;
         sda_oe_n_o <= 1'b1;
      end else begin
         sda_o      <= 1'b0;
         sda_oe_n_o <= ~(ack_drive_reg | (tx_en_reg & ~tx_bit_reg));
      end
   end
endmodule // snvm_slave

// ### test/snvm_master.sv
// bus master model: clock and open-drain data
`timescale 1ns/1ps
module snvm_master (
   input  wire clk_i,
   input  wire line_i,
   output reg  scl_o,
   output reg  sda_o
);
   // half period in clk; 10 gives the 1 MHz top rate, the fastest the slave takes
   integer h = 10;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task w(input integer n);
      repeat (n) @(posedge clk_i);
   endtask
   // set while low, read mid high
   task bit_io(input b, output r);
      begin
         w(h / 2);
         sda_o <= b;
         w(h / 2);
         scl_o <= 1'b1;
         w(h / 2);
         r = line_i;
         w(h / 2);
         scl_o <= 1'b0;
      end
   endtask
   task start;
      begin
         sda_o <= 1'b1;
         w(h);
         scl_o <= 1'b1;
         w(h);
         sda_o <= 1'b0;
         w(h);
         scl_o <= 1'b0;
      end
   endtask
   task stop;
      begin
         w(h / 2);
         sda_o <= 1'b0;
         w(h / 2);
         scl_o <= 1'b1;
         w(h);
         sda_o <= 1'b1;
         w(h);
      end
   endtask
   // ninth bit: master ack or nack on reads
   task xfer(input [7:0] d, input b9, output [7:0] q, output a);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1)
            bit_io(d[i], q[i]);
         bit_io(b9, a);
      end
   endtask
endmodule // snvm_master

// ### test/snvm_slave_bench.sv
// bench for the serial memory slave
`timescale 1ns/1ps
`include "snvm_regs.vh"
module snvm_slave_bench;
   reg        clk_i = 1'b0;
   reg        srst_i = 1'b1;
   reg        wp_i = 1'b0;
   wire       scl;
   wire       msda;
   wire       sda_o;
   wire       oe_n;
   wire       busy;
   // wired-and with pull-up
   wire       line = msda & (oe_n | sda_o);
   integer    errors = 0;
   integer    n_compared = 0;
   reg  [7:0] q;
   reg        a;
   snvm_slave u_snvm_slave (.clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(line),
      .wp_i(wp_i), .sda_o(sda_o), .sda_oe_n_o(oe_n), .busy_o(busy));
   snvm_master u_snvm_master (.clk_i(clk_i), .line_i(line), .scl_o(scl), .sda_o(msda));
   initial forever #25 clk_i = ~clk_i;
   task chk(input [79:0] nm, input [7:0] e, input [7:0] s);
      begin
         n_compared = n_compared + 1;
         if (s !== e) begin
            errors = errors + 1;
            $display("MISMATCH %0s exp %h got %h", nm, e, s);
         end
      end
   endtask
   task complete_run;
      begin
         $display("compared %0d errors %0d", n_compared, errors);
         if (errors == 0 && n_compared > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task dev(input [2:0] sg, input rw);
      begin
         u_snvm_master.start;
         u_snvm_master.xfer({`SNVM_DEV_TYPE, sg, rw}, 1'b1, q, a);
         chk("dev ack", 8'h00, {7'h00, a});
      end
   endtask
   task wb(input [7:0] d, input e);
      begin
         u_snvm_master.xfer(d, 1'b1, q, a);
         chk("wr ack", {7'h00, e}, {7'h00, a});
      end
   endtask
   task rb(input [7:0] e, input last);
      begin
         u_snvm_master.xfer(8'hFF, last, q, a);
         chk("rd data", e, q);
      end
   endtask
   task seta(input [2:0] sg, input [7:0] wa);
      begin
         dev(sg, 1'b0);
         wb(wa, 1'b0);
         u_snvm_master.stop;
      end
   endtask
   // write then read back at once, no polling between
   task wrrd(input [2:0] sg, input [7:0] wa, input [7:0] d);
      begin
         dev(sg, 1'b0);
         wb(wa, 1'b0);
         wb(d, 1'b0);
         u_snvm_master.stop;
         seta(sg, wa);
         dev(sg, 1'b1);
         rb(d, 1'b1);
         u_snvm_master.stop;
      end
   endtask
   task t_basic;
      begin
         dev(3'h3, 1'b0);
         wb(8'h45, 1'b0);
         wb(8'hA5, 1'b0);
         wb(8'h5A, 1'b0);
         u_snvm_master.stop;
         seta(3'h3, 8'h45);
         dev(3'h3, 1'b1);
         rb(8'hA5, 1'b0);
         rb(8'h5A, 1'b1);
         u_snvm_master.stop;
         chk("busy", 8'h00, {7'h00, busy});
         $display("t_basic done");
      end
   endtask
   task t_wrap;
      begin
         dev(3'h7, 1'b0);
         wb(8'hFF, 1'b0);
         wb(8'h3C, 1'b0);
         wb(8'hC3, 1'b0);
         u_snvm_master.stop;
         seta(3'h7, 8'hFF);
         dev(3'h7, 1'b1);
         rb(8'h3C, 1'b1);
         u_snvm_master.stop;
         seta(3'h0, 8'h00);
         dev(3'h0, 1'b1);
         rb(8'hC3, 1'b1);
         u_snvm_master.stop;
         $display("t_wrap done");
      end
   endtask
   task t_wp;
      begin
         wrrd(3'h1, 8'h10, 8'h11);
         wp_i <= 1'b1;
         dev(3'h1, 1'b0);
         wb(8'h10, 1'b0);
         wb(8'h77, 1'b1);
         u_snvm_master.stop;
         wp_i <= 1'b0;
         dev(3'h1, 1'b1);
         rb(8'h11, 1'b1);
         u_snvm_master.stop;
         wp_i <= 1'bz;
         dev(3'h1, 1'b0);
         wb(8'h20, 1'b0);
         wb(8'h22, 1'b0);
         u_snvm_master.stop;
         wp_i <= 1'b0;
         $display("t_wp done");
      end
   endtask
   task t_foreign;
      begin
         u_snvm_master.start;
         u_snvm_master.xfer(8'h30, 1'b1, q, a);
         chk("foreign", 8'h01, {7'h00, a});
         chk("busy", 8'h00, {7'h00, busy});
         u_snvm_master.stop;
         $display("t_foreign done");
      end
   endtask
   task t_slow;
      begin
         // just under 400 kHz, then 100 kHz
         u_snvm_master.h = 26;
         wrrd(3'h6, 8'h81, 8'h69);
         u_snvm_master.h = 100;
         wrrd(3'h2, 8'h20, 8'h96);
         u_snvm_master.h = 10;
         $display("t_slow done");
      end
   endtask
   // reset mid-frame while the slave still holds its ack
   task t_reset;
      begin
         dev(3'h5, 1'b0);
         srst_i <= 1'b1;
         repeat (10) @(posedge clk_i);
         srst_i <= 1'b0;
         repeat (4) @(posedge clk_i);
         chk("rst oe", 8'h01, {7'h00, oe_n});
         chk("rst busy", 8'h00, {7'h00, busy});
         u_snvm_master.stop;
         dev(3'h0, 1'b1);
         rb(8'hC3, 1'b1);
         u_snvm_master.stop;
         $display("t_reset done");
      end
   endtask
   initial begin
      #4000000;
      errors = errors + 1;
      complete_run;
   end
   initial begin
      repeat (10) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("idle oe", 8'h01, {7'h00, oe_n});
      chk("idle busy", 8'h00, {7'h00, busy});
      t_basic;
      t_wrap;
      t_wp;
      t_foreign;
      t_slow;
      t_reset;
      complete_run;
   end
endmodule // snvm_slave_bench

// ### test/snvm_slave_checker.sv
// port checks for the serial memory slave
`timescale 1ns/1ps
module snvm_slave_checker (
   input wire clk_i,
   input wire srst_i,
   input wire scl_i,
   input wire sda_i,
   input wire wp_i,
   input wire sda_o,
   input wire sda_oe_n_o,
   input wire busy_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   sequence s_start;
      scl_i && $fell(sda_i);
   endsequence
   sequence s_stop;
      scl_i && $rose(sda_i);
   endsequence
   a_never_high:
      assert property (!sda_oe_n_o |-> !sda_o) else $error("line driven high");
   a_reset_idle:
      assert property ($fell(srst_i) |-> sda_oe_n_o && !busy_o) else $error("not idle");
   a_change_low:
      assert property ($changed(sda_oe_n_o) |-> !scl_i) else $error("change at clock high");
   a_start_free:
      assert property (s_start |-> sda_oe_n_o) else $error("held at start");
   a_stop_idle:
      assert property (s_stop |-> ##[1:8] !busy_o) else $error("busy after stop");
   a_bit_hold:
      assert property ($fell(sda_oe_n_o) |-> !sda_oe_n_o [*8]) else $error("low bit short");
   a_release_hold:
      assert property ($rose(sda_oe_n_o) |-> sda_oe_n_o [*8]) else $error("release short");
   a_drive_busy:
      assert property (!sda_oe_n_o |-> busy_o) else $error("drive while idle");
endmodule // snvm_slave_checker
bind snvm_slave snvm_slave_checker u_chk (.clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_i),
   .sda_i(sda_i), .wp_i(wp_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .busy_o(busy_o));
